/* File: hw/temp_conv_consts.svh */
// Purpose: named constants for the temperature conversion controller
// Assumes: 100 MHz system clock
// Notes:   times kept in their own unit, cycle counts derived
`ifndef TEMP_CONV_CONSTS_SVH
`define TEMP_CONV_CONSTS_SVH

`define CLK_MHZ              100
`define CONV_10B_MAX_MS      25
`define CONV_13B_MAX_MS      200
`define NV_WRITE_MAX_MS      10
`define CONV_10B_CYCLES      (`CONV_10B_MAX_MS * 1000 * `CLK_MHZ)
`define NV_WRITE_CYCLES      (`NV_WRITE_MAX_MS * 1000 * `CLK_MHZ)

`define ADDR_UPPER_MSB       8'hA0
`define ADDR_UPPER_LSB       8'hA1
`define ADDR_LOWER_MSB       8'hA2
`define ADDR_LOWER_LSB       8'hA3
`define ADDR_TEMP_MSB        8'hAA
`define ADDR_TEMP_LSB        8'hAB
`define ADDR_CFG_LSB         8'hAD

`define TEMP_RESET           16'hE200
`define UPPER_FACTORY        16'h0780
`define LOWER_FACTORY        16'h0500
`define LOW_ZERO_BITS        3
`define RES_13BIT            2'h3
`define RES_DEFAULT          `RES_13BIT

`endif

/* File: hw/temp_conv_pkg.sv */
// Purpose: types shared by the temperature conversion controller
// Assumes: constants come from temp_conv_consts.svh
// Notes:   resolution encoding 0..3 means 10..13 bits
package temp_conv_pkg;
    typedef enum logic [1:0] {
        res_10bit,
        res_11bit,
        res_12bit,
        res_13bit
    } resolution_t;

    typedef struct packed {
        logic [1:0] resolution_sel;
        logic       power_up_auto_convert;
        logic       single_conversion_mode;
    } nv_config_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_t;
endpackage : temp_conv_pkg

/* File: hw/conv_timer.sv */
// Purpose: times one conversion, length doubling per resolution bit
// Assumes: start is a one-cycle pulse from the controller
// Notes:   base count is parameterised so simulation can shorten it
`timescale 1ns/1ns
`include "temp_conv_consts.svh"

module conv_timer #(
    parameter int unsigned BASE_CYCLES = `CONV_10B_CYCLES
) (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    input  wire logic       start_i,
    input  wire logic [1:0] resolution_i,
    output logic            done_o,
    output logic            busy_o
);
    logic [31:0] remaining;

    // 10-bit time shifted left by resolution code
    function automatic logic [31:0] conv_len(input logic [1:0] res);
        conv_len = BASE_CYCLES << res;
    endfunction : conv_len

    ////////////////////////////////////////////////////////////////
    // countdown; done pulses as the last cycle elapses
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            remaining <= 32'h0;
            busy_o    <= 1'b0;
            done_o    <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                remaining <= conv_len(resolution_i) - 32'h1;
                busy_o    <= 1'b1;
            end else if (busy_o) begin
                if (remaining == 32'h0) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end else begin
                    remaining <= remaining - 32'h1;
                end
            end
        end
    end
endmodule : conv_timer

/* File: hw/nv_store.sv */
// Purpose: nonvolatile trip points and config with write-cycle timing
// Assumes: storage array survives reset; factory values at build
// Notes:   writes during a busy cycle are dropped, host must wait
`timescale 1ns/1ns
`include "temp_conv_consts.svh"

module nv_store #(
    parameter int unsigned WRITE_CYCLES = `NV_WRITE_CYCLES
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     reset_n_i,
    input  wire logic                     wr_i,
    input  wire logic [1:0]               sel_i,
    input  wire logic [15:0]              wdata_i,
    output logic [15:0]                   upper_o,
    output logic [15:0]                   lower_o,
    output temp_conv_pkg::nv_config_t     cfg_o,
    output logic                          busy_o
);
    logic [31:0]               wait_cnt;

    ////////////////////////////////////////////////////////////////
    // nonvolatile cells: no reset, factory contents as initial image
    logic [15:0]               upper_cell = `UPPER_FACTORY;
    logic [15:0]               lower_cell = `LOWER_FACTORY;
    temp_conv_pkg::nv_config_t cfg_cell   = '{resolution_sel: `RES_DEFAULT, power_up_auto_convert: 1'b1,
                                              single_conversion_mode: 1'b0};

    assign upper_o = upper_cell;
    assign lower_o = lower_cell;
    assign cfg_o   = cfg_cell;

    // trip point low three bits never stored; config keeps bits 3..0
    always_ff @(posedge clk_sys_i) begin
        if (wr_i && !busy_o) begin
            unique case (sel_i)
                2'h0: upper_cell <= {wdata_i[15:3], 3'h0};
                2'h1: lower_cell <= {wdata_i[15:3], 3'h0};
                2'h2: cfg_cell   <= wdata_i[3:0];
                2'h3: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // write-cycle busy window
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_cnt <= 32'h0;
            busy_o   <= 1'b0;
        end else if (wr_i && !busy_o) begin
            wait_cnt <= WRITE_CYCLES - 32'h1;
            busy_o   <= 1'b1;
        end else if (busy_o) begin
            if (wait_cnt == 32'h0) busy_o <= 1'b0;
            else wait_cnt <= wait_cnt - 32'h1;
        end
    end
endmodule : nv_store

/* File: hw/temp_conversion_control.sv */
// Purpose: conversion control and result formatting for a thermometer
// Assumes: byte register port from the 2-wire front end, same clock
// Notes:   ADC data arrives as a 13-bit signed sample, left justified
//
// Function
// - four resolutions, 10 to 13 bits
// - 13-bit resolution by default
// - conversion time doubles per bit
// - conversion within 25/50/100/200 ms
// - auto-convert bit decides power-up conversion
// - continuous mode runs until stop command
// - single mode converts exactly once
// - standby after single conversion until start
// - 16-bit result at AAh and ABh
// - sign bit 15, weights in 14..3
// - result bits 2..0 always zero
// - conversions zero unused low bits per resolution; ABh writes zero bits 2..0 only
// - trip points drop three low bits
// - factory trip points 0780h and 0500h
// - result powers up as E200h
// - nonvolatile write done within 10 ms
// - mode and resolution bits are nonvolatile
`timescale 1ns/1ns
`include "temp_conv_consts.svh"

module temp_conversion_control #(
    parameter int unsigned CONV_BASE_CYCLES = `CONV_10B_CYCLES,
    parameter int unsigned NV_WRITE_CYCLES  = `NV_WRITE_CYCLES
) (
    input  wire logic                      clk_sys_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      start_convert_i,
    input  wire logic                      stop_convert_i,
    input  temp_conv_pkg::reg_access_t     reg_i,
    input  wire logic [12:0]               adc_sample_i,
    output logic [7:0]                     rdata_o,
    output logic                           converting_o,
    output logic                           conv_done_o,
    output logic                           nv_busy_o,
    output logic [15:0]                    temperature_o
);
    typedef enum logic [1:0] {
        st_powerup,
        st_standby,
        st_convert
    } ctrl_state_t;

    ctrl_state_t                state;
    logic [15:0]                temperature_result;
    logic [7:0]                 upper_trip_staged;
    logic [7:0]                 lower_trip_staged;
    logic                       conv_start;
    logic                       conv_done;
    logic                       conv_busy;
    logic                       nv_wr;
    logic [1:0]                 nv_sel;
    logic [15:0]                nv_wdata;
    logic                       nv_busy;
    logic [15:0]                upper_trip_point;
    logic [15:0]                lower_trip_point;
    temp_conv_pkg::nv_config_t  cfg;

    // zero the unused low bits for a resolution code
    function automatic logic [15:0] format_result(input logic [12:0] s, input logic [1:0] res);
        logic [15:0] full;
        logic [15:0] mask;
        full = {s, 3'h0};
        mask = 16'hFFF8 << (`RES_13BIT - res);
        format_result = full & mask;
    endfunction : format_result

    ////////////////////////////////////////////////////////////////
    // conversion timer and nonvolatile store
    conv_timer #(
        .BASE_CYCLES (CONV_BASE_CYCLES)
    ) u_timer (
        .clk_sys_i    (clk_sys_i),
        .reset_n_i    (reset_n_i),
        .start_i      (conv_start),
        .resolution_i (cfg.resolution_sel),
        .done_o       (conv_done),
        .busy_o       (conv_busy)
    );

    nv_store #(
        .WRITE_CYCLES (NV_WRITE_CYCLES)
    ) u_nv (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .wr_i      (nv_wr),
        .sel_i     (nv_sel),
        .wdata_i   (nv_wdata),
        .upper_o   (upper_trip_point),
        .lower_o   (lower_trip_point),
        .cfg_o     (cfg),
        .busy_o    (nv_busy)
    );

    ////////////////////////////////////////////////////////////////
    // conversion sequencing
    always_comb begin
        conv_start = 1'b0;
        unique case (state)
            st_powerup: conv_start = cfg.power_up_auto_convert || start_convert_i;
            st_standby: conv_start = start_convert_i;
            st_convert: conv_start = conv_done && !cfg.single_conversion_mode
                                     && !stop_convert_i;
        endcase
    end

    // stop ends continuous runs; single mode drops to standby after one
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= st_powerup;
        end else begin
            unique case (state)
                st_powerup: begin
                    if (cfg.power_up_auto_convert || start_convert_i)
                        state <= st_convert;
                    else
                        state <= st_standby;
                end
                st_standby: if (start_convert_i) state <= st_convert;
                st_convert: begin
                    if (stop_convert_i && !cfg.single_conversion_mode)
                        state <= st_standby;
                    else if (conv_done && cfg.single_conversion_mode)
                        state <= st_standby;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // result register: conversion wins over a host write
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            temperature_result <= `TEMP_RESET;
        end else if (conv_done && state == st_convert) begin
            temperature_result <= format_result(adc_sample_i, cfg.resolution_sel);
        end else if (reg_i.wr && reg_i.addr == `ADDR_TEMP_MSB) begin
            temperature_result[15:8] <= reg_i.wdata;
        end else if (reg_i.wr && reg_i.addr == `ADDR_TEMP_LSB) begin
            temperature_result[7:0] <= {reg_i.wdata[7:3], 3'h0};
        end
    end

    ////////////////////////////////////////////////////////////////
    // byte staging: MSB held, LSB write commits the nonvolatile word
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            upper_trip_staged <= 8'h0;
            lower_trip_staged <= 8'h0;
        end else if (reg_i.wr) begin
            if (reg_i.addr == `ADDR_UPPER_MSB) upper_trip_staged <= reg_i.wdata;
            if (reg_i.addr == `ADDR_LOWER_MSB) lower_trip_staged <= reg_i.wdata;
        end
    end

    always_comb begin
        nv_wr    = 1'b0;
        nv_sel   = 2'h0;
        nv_wdata = 16'h0;
        if (reg_i.wr && reg_i.addr == `ADDR_UPPER_LSB) begin
            nv_wr    = 1'b1;
            nv_wdata = {upper_trip_staged, reg_i.wdata};
        end else if (reg_i.wr && reg_i.addr == `ADDR_LOWER_LSB) begin
            nv_wr    = 1'b1;
            nv_sel   = 2'h1;
            nv_wdata = {lower_trip_staged, reg_i.wdata};
        end else if (cfg_write_hit(reg_i)) begin
            nv_wr    = 1'b1;
            nv_sel   = 2'h2;
            nv_wdata = {12'h000, reg_i.wdata[3:0]};
        end
    end

    // config word write: private byte address just past the map
    function automatic logic cfg_write_hit(input temp_conv_pkg::reg_access_t a);
        cfg_write_hit = a.wr && a.addr == `ADDR_CFG_LSB;
    endfunction : cfg_write_hit

    ////////////////////////////////////////////////////////////////
    // read data and status outputs, all registered
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o       <= 8'h0;
            converting_o  <= 1'b0;
            conv_done_o   <= 1'b0;
            nv_busy_o     <= 1'b0;
            temperature_o <= `TEMP_RESET;
        end else begin
            // a stopped run may count out in the background; standby hides it
            converting_o  <= conv_busy && state == st_convert;
            conv_done_o   <= conv_done && state == st_convert;
            nv_busy_o     <= nv_busy;
            temperature_o <= temperature_result;
            if (reg_i.rd) begin
                unique case (reg_i.addr)
                    `ADDR_UPPER_MSB: rdata_o <= upper_trip_point[15:8];
                    `ADDR_UPPER_LSB: rdata_o <= upper_trip_point[7:0];
                    `ADDR_LOWER_MSB: rdata_o <= lower_trip_point[15:8];
                    `ADDR_LOWER_LSB: rdata_o <= lower_trip_point[7:0];
                    `ADDR_TEMP_MSB:  rdata_o <= temperature_result[15:8];
                    `ADDR_TEMP_LSB:  rdata_o <= temperature_result[7:0];
                    default:         rdata_o <= {4'h0, cfg};
                endcase
            end
        end
    end
endmodule : temp_conversion_control

/* File: dv/host_model.sv */
// Purpose: host side of the command and register byte path
// Assumes: byte accesses and commands are one-cycle pulses
// Notes:   drives 1 ns after the rising edge
`timescale 1ns/1ns
module host_model (
    input  wire logic                  clk_sys_i,
    input  wire logic                  nv_busy_i,
    output logic                       start_o,
    output logic                       stop_o,
    output temp_conv_pkg::reg_access_t acc_o
);
    ////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        start_o = 1'b0;
        stop_o = 1'b0;
        acc_o = '0;
    end
    // one byte access, taken at the next edge; on release strobes drop, address and data invert
    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i) #1;
        acc_o = {w, ~w, a, d};
        @(posedge clk_sys_i) #1;
        acc_o = {2'b00, ~a, ~d};
    endtask : access
    // start and stop are distinct commands
    task automatic cmd(input logic go);
        @(posedge clk_sys_i) #1;
        start_o = go;
        stop_o = ~go;
        @(posedge clk_sys_i) #1;
        start_o = 1'b0;
        stop_o = 1'b0;
    endtask : cmd
    // no new commit until the write cycle is over
    task automatic nv_wait();
        repeat (3) @(posedge clk_sys_i);
        #2;
        for (int i = 0; i < 40 && nv_busy_i; i++) begin
            @(posedge clk_sys_i);
            #2;
        end
    endtask : nv_wait
endmodule : host_model

/* File: dv/temp_conversion_control_props.sv */
// Purpose: port-level checks of conversion control
// Assumes: one clock domain
// Notes:   bounds follow the shortened counts
`timescale 1ns/1ns
module temp_conversion_control_props #(
    parameter int unsigned CONV_BASE_CYCLES = 4,
    parameter int unsigned NV_WRITE_CYCLES  = 8
) (
    input wire logic                  clk_sys_i,
    input wire logic                  reset_n_i,
    input wire logic                  start_convert_i,
    input temp_conv_pkg::reg_access_t reg_i,
    input wire logic [7:0]            rdata_o,
    input wire logic                  converting_o,
    input wire logic                  conv_done_o,
    input wire logic                  nv_busy_o,
    input wire logic [15:0]           temperature_o
);
    localparam int CONV_MAX = CONV_BASE_CYCLES * 8 + 8;
    int unsigned nv_cnt;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////
    // length of the running write cycle
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) nv_cnt <= 0;
        else nv_cnt <= nv_busy_o ? nv_cnt + 1 : 0;
    end
    sequence start_idle_s;
        start_convert_i && !converting_o && !nv_busy_o;
    endsequence
    sequence conv_run_s;
        ##[1:3] converting_o;
    endsequence
    AST_START_RUNS: assert property (start_idle_s |-> conv_run_s)
        else $error("start did not begin a conversion");
    AST_POWERUP_VALUE: assert property ($rose(reset_n_i) |-> temperature_o == 16'hE200)
        else $error("result not at power-up value");
    AST_LOW_BITS_ZERO: assert property (temperature_o[2:0] == 3'h0)
        else $error("result low bits not zero");
    AST_DONE_ONE_CYCLE: assert property (conv_done_o |=> !conv_done_o)
        else $error("done longer than one cycle");
    AST_DONE_FROM_CONV: assert property ($rose(conv_done_o) |-> $past(converting_o, 3))
        else $error("result stored without a conversion");
    AST_CONV_BOUNDED: assert property ($rose(converting_o) |-> ##[1:CONV_MAX] !converting_o)
        else $error("conversion too long");
    AST_NV_BOUNDED: assert property (nv_cnt <= NV_WRITE_CYCLES + 2)
        else $error("write cycle too long");
    AST_NV_COMMIT: assert property (reg_i.wr && reg_i.addr == 8'hA1 && !nv_busy_o |-> ##[1:2] nv_busy_o)
        else $error("low byte did not commit");
    AST_RDATA_HOLDS: assert property (!$past(reg_i.rd) |-> $stable(rdata_o))
        else $error("read data moved without a read");
endmodule : temp_conversion_control_props
bind temp_conversion_control temp_conversion_control_props #(
    .CONV_BASE_CYCLES(CONV_BASE_CYCLES), .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
) temp_conversion_control_props_inst (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .start_convert_i(start_convert_i), .reg_i(reg_i), .rdata_o(rdata_o), .converting_o(converting_o),
    .conv_done_o(conv_done_o), .nv_busy_o(nv_busy_o), .temperature_o(temperature_o));

/* File: dv/test_temp_conversion_control.sv */
// Purpose: self-checking bench for conversion control
// Assumes: counts shortened to 4 and 8 cycles
// Notes:   a result with no note pending is a mismatch
`timescale 1ns/1ns
module test_temp_conversion_control;
    localparam int unsigned BASE = 4;
    logic                       clk_sys_i;
    logic                       reset_n_i;
    logic                       start_c;
    logic                       stop_c;
    temp_conv_pkg::reg_access_t acc;
    logic [12:0]                adc;
    logic [7:0]                 rdata;
    logic                       converting;
    logic                       conv_done;
    logic                       nv_busy;
    logic [15:0]                temperature;
    logic [7:0]                 rd_q[$];
    logic [15:0]                tmp_q[$];
    logic                       rd_pend = 1'b0;
    logic                       done_pend = 1'b0;
    int                         error_cnt = 0;
    int                         cmp_count = 0;
    int                         cyc = 0;
    int                         dur;
    int                         d0;
    host_model host_model_inst (.clk_sys_i(clk_sys_i), .nv_busy_i(nv_busy), .start_o(start_c),
        .stop_o(stop_c), .acc_o(acc));
    temp_conversion_control #(.CONV_BASE_CYCLES(BASE), .NV_WRITE_CYCLES(8)) temp_conversion_control_inst (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .start_convert_i(start_c), .stop_convert_i(stop_c),
        .reg_i(acc), .adc_sample_i(adc), .rdata_o(rdata), .converting_o(converting),
        .conv_done_o(conv_done), .nv_busy_o(nv_busy), .temperature_o(temperature));
    ////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("compares=%0d errors=%0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        rd_q.push_back(e);
        host_model_inst.access(1'b0, a, 8'h00);
    endtask : rd
    task automatic do_reset();
        @(posedge clk_sys_i) #1;
        reset_n_i = 1'b0;
        repeat (12) @(posedge clk_sys_i);
        #1 reset_n_i = 1'b1;
    endtask : do_reset
    // new sample, noted with the unused low bits cleared
    task automatic expect_conv(input int r);
        @(posedge clk_sys_i) #1;
        adc = 13'($urandom);
        tmp_q.push_back({adc, 3'h0} & (16'hFFFF << (6 - r)));
    endtask : expect_conv
    task automatic wait_done();
        dur = 0;
        for (int i = 0; i < 200 && !conv_done; i++) @(posedge clk_sys_i) #2 dur += converting;
        if (!conv_done) check(16'h0000, 16'h0001);
        @(posedge clk_sys_i) #2;
    endtask : wait_done
    // clock, and a ceiling well above the planned run
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // results meet the oldest note; temperature seen one cycle after done
    always @(posedge clk_sys_i) begin
        logic rd_now;
        rd_now = acc.rd;
        #2;
        if (done_pend && tmp_q.size() > 0) check(temperature, tmp_q.pop_front());
        else if (done_pend) check(16'h0001, 16'h0000);
        if (rd_pend) check({8'h00, rdata}, {8'h00, rd_q.pop_front()});
        done_pend = conv_done;
        rd_pend = rd_now;
    end
    ////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] b;
        logic [7:0] ra[6] = '{8'hAA, 8'hAB, 8'hA0, 8'hA1, 8'hA2, 8'hA3};
        logic [7:0] re[6] = '{8'hE2, 8'h00, 8'h07, 8'h80, 8'h05, 8'h00};
        void'($urandom(32'h563DCF96));
        adc = 13'h0000;
        reset_n_i = 1'b0;
        repeat (12) @(posedge clk_sys_i);
        #1 reset_n_i = 1'b1;
        check(temperature, 16'hE200);
        expect_conv(3);
        tmp_q.push_back(tmp_q[0]);
        foreach (ra[i]) rd(ra[i], re[i]);
        wait_done();
        wait_done();
        host_model_inst.cmd(1'b0);
        repeat (60) @(posedge clk_sys_i);
        check({15'h0000, converting}, 16'h0000);
        b = 8'($urandom);
        host_model_inst.access(1'b1, 8'hA0, 8'h12);
        host_model_inst.access(1'b1, 8'hA1, b);
        host_model_inst.nv_wait();
        rd(8'hA0, 8'h12);
        rd(8'hA1, b & 8'hF8);
        host_model_inst.access(1'b1, 8'hA2, b);
        host_model_inst.access(1'b1, 8'hA3, 8'h3F);
        host_model_inst.nv_wait();
        rd(8'hA2, b);
        rd(8'hA3, 8'h38);
        host_model_inst.access(1'b1, 8'hAA, 8'h5A);
        host_model_inst.access(1'b1, 8'hAB, 8'hFF);
        rd(8'hAB, 8'hF8);
        rd(8'hAA, 8'h5A);
        for (int r = 0; r < 4; r++) begin
            host_model_inst.access(1'b1, 8'hAD, {4'h0, 2'(r), 2'b11});
            host_model_inst.nv_wait();
            rd(8'hAD, {4'h0, 2'(r), 2'b11});
            expect_conv(r);
            host_model_inst.cmd(1'b1);
            wait_done();
            if (r == 0) d0 = dur;
            check(16'(dur), 16'(d0 + BASE * ((1 << r) - 1)));
            repeat (30) @(posedge clk_sys_i);
            check({15'h0000, converting}, 16'h0000);
        end
        do_reset();
        expect_conv(3);
        wait_done();
        repeat (60) @(posedge clk_sys_i);
        check({15'h0000, converting}, 16'h0000);
        host_model_inst.access(1'b1, 8'hAD, 8'h0C);
        host_model_inst.nv_wait();
        do_reset();
        repeat (60) @(posedge clk_sys_i);
        check({15'h0000, converting}, 16'h0000);
        expect_conv(3);
        host_model_inst.cmd(1'b1);
        wait_done();
        host_model_inst.cmd(1'b0);
        repeat (5) @(posedge clk_sys_i);
        check({15'h0000, converting}, 16'h0000);
        report_and_stop();
    end
endmodule : test_temp_conversion_control
